// ### design/smsr_pkg.sv
package smsr_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_IRQ_FLAGS = 10'h00C;
  localparam logic [9:0] IDX_RX_STAT = 10'h018;
  localparam logic [9:0] IDX_RX_DATA = 10'h01A;
  localparam logic [9:0] IDX_IRQ_EN = 10'h08C;
  localparam logic [9:0] IDX_TX_STAT = 10'h098;
  localparam logic [9:0] IDX_BAUD_DIV = 10'h099;
  localparam int ADDR_W = 12;
  // reset values
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_RX_STAT = 8'h00;
  localparam logic [7:0] RST_RX_DATA = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_TX_STAT = 8'h02;
  localparam logic [7:0] RST_BAUD_DIV = 8'h00;
  // receive status and control fields
  localparam int RX_SERIAL_PORT_ENABLE_BIT = 7;
  localparam int RX_NINE_BIT = 6;
  localparam int RX_SINGLE_RECEIVE_ENABLE_BIT = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
  localparam int RX_ADDRESS_DETECT_ENABLE_BIT = 3;
  localparam int RX_FRAMING_ERROR_FLAG_BIT = 2;
  localparam int RX_OVERRUN_ERROR_FLAG_BIT = 1;
  localparam int RX_D9_BIT = 0;
  // transmit status and control fields
  localparam int TX_CLOCK_SOURCE_SELECT_BIT = 7;
  localparam int TX_SYNC_BIT = 4;
  localparam int TX_SHIFT_REGISTER_EMPTY_BIT = 1;
  localparam logic [7:0] TX_IMPL_MASK = 8'hF7;
  // interrupt flag / enable position
  localparam int IRQ_RX_BIT = 5;
  // word length: last bit index for 8 and 9 bit words
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  // baud ticks per half of the shift clock (period = 4 ticks)
  localparam logic HALF_TICKS_M1 = 1'b1;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### design/smsr_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a pin level
module smsr_sync
(
  input wire logic clk_in, // system clock
  input wire logic rst_in, // async reset, high
  input wire logic d_in, // asynchronous level
  output logic q_out // synchronised level
);
  logic meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_reg <= 1'b0;
      q_out <= 1'b0;
    end
    else
    begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule

// ### design/smsr_top.sv
`timescale 1ns/1ps
// Functional notes
// [R1] shift clock is clock over 4(divisor+1)
// [R2] every 8-bit divisor value is valid
// [R3] either receive enable starts reception
// [R4] data sampled at shift clock falling edge
// [R5] single enable receives exactly one word
// [R6] continuous enable receives until cleared
// [R7] both enables set means continuous
// [R8] software sets mode bits after divisor
// [R9] software clears enables before configuring
// [R10] ninth bit captured into status register
// [R11] completion sets flag, irq when enabled
// [R12] eight data bits in data register
// [R13] clearing continuous enable clears errors
// [R14] unimplemented bits read as zero
// [R15] software keeps parallel port bits clear
// [R16] baud generator is free-running 8-bit timer
// [R17] divisor write resets baud timer
// [R18] lsb first, eight or nine clocks
// [R19] single enable cleared when word done; here it stays set when continuous enable is also set
module smsr_top
  import smsr_pkg::*;
(
  input wire logic CLK_IN, // 20 MHz system clock
  input wire logic SYS_RST_IN, // async reset, high
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN, // write address
  input wire logic S_AXI_AWVALID_IN, // write address valid
  output logic S_AXI_AWREADY_OUT, // write address ready
  input wire logic [31:0] S_AXI_WDATA_IN, // write data
  input wire logic [3:0] S_AXI_WSTRB_IN, // write strobes
  input wire logic S_AXI_WVALID_IN, // write data valid
  output logic S_AXI_WREADY_OUT, // write data ready
  output logic [1:0] S_AXI_BRESP_OUT, // write response
  output logic S_AXI_BVALID_OUT, // write response valid
  input wire logic S_AXI_BREADY_IN, // write response ready
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN, // read address
  input wire logic S_AXI_ARVALID_IN, // read address valid
  output logic S_AXI_ARREADY_OUT, // read address ready
  output logic [31:0] S_AXI_RDATA_OUT, // read data
  output logic [1:0] S_AXI_RRESP_OUT, // read response
  output logic S_AXI_RVALID_OUT, // read data valid
  input wire logic S_AXI_RREADY_IN, // read data ready
  input wire logic SERIAL_DATA_LINE_IN, // data from slave
  output logic SERIAL_CLOCK_LINE_OUT, // shift clock level
  output logic SERIAL_CLOCK_LINE_OE_OUT, // shift clock drive enable
  output logic IRQ_OUT // level interrupt
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} smsr_state_t;

  smsr_state_t state_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_lane_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] flags_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] tx_stat_reg;
  logic [7:0] div_reg;
  logic [7:0] brg_cnt_reg;
  logic serial_port_enable_reg;
  logic nine_reg;
  logic single_receive_enable_reg;
  logic continuous_receive_enable_reg;
  logic address_detect_enable_reg;
  logic overrun_error_flag_reg;
  logic d9_reg;
  logic [7:0] rx_data_reg;
  logic full_reg;
  logic half_reg;
  logic [3:0] bit_cnt_reg;
  logic [8:0] shift_reg;
  logic din_s;
  logic do_wr;
  logic wr_ok;
  logic rd_data_hit;
  logic tick;
  logic rx_on;
  logic sample;
  logic done;
  logic [3:0] last_bit;
  logic [8:0] word;
  logic [7:0] rd_mux;
  logic rd_ok;

  smsr_sync u_data_sync
  (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in(SERIAL_DATA_LINE_IN),
    .q_out(din_s)
  );

  // a write lands once both address and data are held
  assign do_wr = aw_full_reg && w_full_reg && !S_AXI_BVALID_OUT;
  assign wr_ok = aw_addr_reg[1:0] == 2'h0 && (aw_addr_reg[ADDR_W-1:2] == IDX_IRQ_FLAGS
    || aw_addr_reg[ADDR_W-1:2] == IDX_RX_STAT || aw_addr_reg[ADDR_W-1:2] == IDX_RX_DATA
    || aw_addr_reg[ADDR_W-1:2] == IDX_IRQ_EN || aw_addr_reg[ADDR_W-1:2] == IDX_TX_STAT
    || aw_addr_reg[ADDR_W-1:2] == IDX_BAUD_DIV);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    hit = a == {idx, 2'h0};
  endfunction

  // write channels, taken in either order
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      S_AXI_AWREADY_OUT <= 1'b1;
      S_AXI_WREADY_OUT <= 1'b1;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= RESP_OKAY;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end
    else
    begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
      begin
        aw_addr_reg <= S_AXI_AWADDR_IN;
        aw_full_reg <= 1'b1;
        S_AXI_AWREADY_OUT <= 1'b0;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
      begin
        w_data_reg <= S_AXI_WDATA_IN[7:0];
        w_lane_reg <= S_AXI_WSTRB_IN[0];
        w_full_reg <= 1'b1;
        S_AXI_WREADY_OUT <= 1'b0;
      end
      if (do_wr)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
      begin
        S_AXI_BVALID_OUT <= 1'b0;
        S_AXI_AWREADY_OUT <= 1'b1;
        S_AXI_WREADY_OUT <= 1'b1;
      end
    end
  end

  // byte-lane write pulse per register
  function automatic logic wr_to(input logic [9:0] idx);
    wr_to = do_wr && w_lane_reg && hit(aw_addr_reg, idx);
  endfunction

  // read mux; unimplemented bits stay zero
  always_comb
  begin
    rd_mux = 8'h00;
    rd_ok = 1'b1;
    if (hit(S_AXI_ARADDR_IN, IDX_IRQ_FLAGS))
      rd_mux = flags_reg;
    else if (hit(S_AXI_ARADDR_IN, IDX_RX_STAT))
      rd_mux = {serial_port_enable_reg, nine_reg, single_receive_enable_reg, continuous_receive_enable_reg, address_detect_enable_reg, 1'b0, overrun_error_flag_reg, d9_reg};
    else if (hit(S_AXI_ARADDR_IN, IDX_RX_DATA))
      rd_mux = rx_data_reg;
    else if (hit(S_AXI_ARADDR_IN, IDX_IRQ_EN))
      rd_mux = irq_en_reg;
    else if (hit(S_AXI_ARADDR_IN, IDX_TX_STAT))
      rd_mux = tx_stat_reg; // [R14]
    else if (hit(S_AXI_ARADDR_IN, IDX_BAUD_DIV))
      rd_mux = div_reg;
    else
      rd_ok = 1'b0;
  end

  assign rd_data_hit = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && hit(S_AXI_ARADDR_IN, IDX_RX_DATA);

  // read channel, one answer cycle after the address
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      S_AXI_ARREADY_OUT <= 1'b1;
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h0000_0000;
      S_AXI_RRESP_OUT <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
    begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RDATA_OUT <= {24'h00_0000, rd_mux}; // [R14]
      S_AXI_RRESP_OUT <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN)
    begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_ARREADY_OUT <= 1'b1;
    end
  end

  // transmit side bits kept for mode select; empty flag fixed high
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      tx_stat_reg <= RST_TX_STAT;
    else if (wr_to(IDX_TX_STAT))
      tx_stat_reg <= (w_data_reg & TX_IMPL_MASK) | RST_TX_STAT; // [R14]
  end

  // divisor and free-running baud timer
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      div_reg <= RST_BAUD_DIV;
      brg_cnt_reg <= 8'h00;
    end
    else if (wr_to(IDX_BAUD_DIV))
    begin
      div_reg <= w_data_reg; // [R2]
      brg_cnt_reg <= 8'h00; // [R17]
    end
    else
      brg_cnt_reg <= tick ? 8'h00 : brg_cnt_reg + 8'h01; // [R16]
  end

  // high-speed select is ignored here, as in sync mode it must be
  assign tick = brg_cnt_reg == div_reg; // [R1]
  assign rx_on = serial_port_enable_reg && tx_stat_reg[TX_SYNC_BIT] && tx_stat_reg[TX_CLOCK_SOURCE_SELECT_BIT]
    && (single_receive_enable_reg || continuous_receive_enable_reg); // [R3] [R7]
  assign last_bit = nine_reg ? LAST_BIT_9 : LAST_BIT_8; // [R18]
  assign sample = rx_on && state_reg == ST_HIGH && tick && half_reg == HALF_TICKS_M1;
  assign done = sample && bit_cnt_reg == last_bit;
  // word as it stands with the bit being sampled inserted
  always_comb
  begin
    word = shift_reg;
    word[bit_cnt_reg] = din_s; // [R18]
  end

  // shift clock sequencer: two ticks low, two high, sample on fall
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      state_reg <= ST_IDLE;
      half_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 9'h000;
      SERIAL_CLOCK_LINE_OUT <= 1'b0;
    end
    else if (!rx_on)
    begin
      state_reg <= ST_IDLE; // dropping enables aborts a partial word
      half_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      SERIAL_CLOCK_LINE_OUT <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          state_reg <= ST_LOW; // [R3]
          half_reg <= 1'b0;
          bit_cnt_reg <= 4'h0;
        end
        ST_LOW:
          if (tick)
          begin
            half_reg <= ~half_reg;
            if (half_reg == HALF_TICKS_M1)
            begin
              state_reg <= ST_HIGH;
              SERIAL_CLOCK_LINE_OUT <= 1'b1; // [R1]
            end
          end
        ST_HIGH:
          if (tick)
          begin
            half_reg <= ~half_reg;
            if (sample)
            begin
              SERIAL_CLOCK_LINE_OUT <= 1'b0;
              shift_reg <= word; // [R4]
              bit_cnt_reg <= done ? 4'h0 : bit_cnt_reg + 4'h1; // [R18]
              // continuous goes straight on; single stops clocking
              state_reg <= (done && !continuous_receive_enable_reg) ? ST_IDLE : ST_LOW; // [R5] [R6] [R7]
            end
          end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // drive the clock pin while in synchronous master mode
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      SERIAL_CLOCK_LINE_OE_OUT <= 1'b0;
    else
      SERIAL_CLOCK_LINE_OE_OUT <= serial_port_enable_reg && tx_stat_reg[TX_SYNC_BIT] && tx_stat_reg[TX_CLOCK_SOURCE_SELECT_BIT];
  end

  // receive status and control; hardware sets win over clears
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      {serial_port_enable_reg, nine_reg, single_receive_enable_reg, continuous_receive_enable_reg, address_detect_enable_reg} <= RST_RX_STAT[7:3];
      overrun_error_flag_reg <= RST_RX_STAT[RX_OVERRUN_ERROR_FLAG_BIT];
    end
    else
    begin
      if (wr_to(IDX_RX_STAT))
      begin
        serial_port_enable_reg <= w_data_reg[RX_SERIAL_PORT_ENABLE_BIT];
        nine_reg <= w_data_reg[RX_NINE_BIT];
        single_receive_enable_reg <= w_data_reg[RX_SINGLE_RECEIVE_ENABLE_BIT];
        continuous_receive_enable_reg <= w_data_reg[RX_CONTINUOUS_RECEIVE_ENABLE_BIT];
        address_detect_enable_reg <= w_data_reg[RX_ADDRESS_DETECT_ENABLE_BIT];
      end
      else if (done && !continuous_receive_enable_reg)
        single_receive_enable_reg <= 1'b0; // [R19]
      if (done && full_reg && !rd_data_hit)
        overrun_error_flag_reg <= 1'b1;
      else if (wr_to(IDX_RX_STAT) && !w_data_reg[RX_CONTINUOUS_RECEIVE_ENABLE_BIT])
        overrun_error_flag_reg <= 1'b0; // [R13]
    end
  end

  // received word holding; unread word is kept, new one dropped
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      rx_data_reg <= RST_RX_DATA;
      d9_reg <= RST_RX_STAT[RX_D9_BIT];
      full_reg <= 1'b0;
    end
    else if (done && (!full_reg || rd_data_hit))
    begin
      rx_data_reg <= word[7:0]; // [R12]
      d9_reg <= nine_reg ? word[8] : 1'b0; // [R10]
      full_reg <= 1'b1;
    end
    else if (rd_data_hit)
      full_reg <= 1'b0;
  end

  // sticky flag, write one to clear; set wins
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      flags_reg <= RST_IRQ_FLAGS;
      irq_en_reg <= RST_IRQ_EN;
    end
    else
    begin
      if (done)
        flags_reg[IRQ_RX_BIT] <= 1'b1; // [R11]
      else if (wr_to(IDX_IRQ_FLAGS) && w_data_reg[IRQ_RX_BIT])
        flags_reg[IRQ_RX_BIT] <= 1'b0;
      if (wr_to(IDX_IRQ_EN))
        irq_en_reg <= w_data_reg;
    end
  end

  // interrupt level, one cycle behind the flag
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      IRQ_OUT <= 1'b0;
    else
      IRQ_OUT <= |(flags_reg & irq_en_reg); // [R11]
  end

  // register writes as plain signals, so properties see sampled values
  logic wr_div_s;
  logic wr_rx_s;
  assign wr_div_s = do_wr && w_lane_reg && hit(aw_addr_reg, IDX_BAUD_DIV);
  assign wr_rx_s = do_wr && w_lane_reg && hit(aw_addr_reg, IDX_RX_STAT);

  // samples since word start, kept apart from the bit counter it checks
  logic [3:0] seen_reg;
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
      seen_reg <= 4'h0;
    else if (!rx_on || done)
      seen_reg <= 4'h0;
    else if (sample)
      seen_reg <= seen_reg + 4'h1;
  end

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  property p_brg_wrap;
    tick && !wr_div_s |=> brg_cnt_reg == 8'h00;
  endproperty
  a_brg_wrap: assert property (p_brg_wrap) else $error("baud timer did not wrap"); // [R16]
  property p_div_reset;
    wr_div_s |=> brg_cnt_reg == 8'h00 && div_reg == $past(w_data_reg);
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divisor write missed timer"); // [R17]
  property p_start;
    state_reg == ST_IDLE && rx_on |=> state_reg == ST_LOW && !SERIAL_CLOCK_LINE_OUT;
  endproperty
  a_start: assert property (p_start) else $error("reception did not start"); // [R3]
  property p_fall;
    sample |-> SERIAL_CLOCK_LINE_OUT ##1 !SERIAL_CLOCK_LINE_OUT;
  endproperty
  a_fall: assert property (p_fall) else $error("sample not at falling edge"); // [R4]
  property p_single;
    done && !continuous_receive_enable_reg && !wr_rx_s |=> !single_receive_enable_reg && state_reg == ST_IDLE;
  endproperty
  a_single: assert property (p_single) else $error("single word did not stop"); // [R19]
  property p_cont;
    done && continuous_receive_enable_reg |=> state_reg == ST_LOW || !rx_on;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous reception stopped"); // [R6]
  property p_bits;
    done |-> seen_reg == (nine_reg ? LAST_BIT_9 : LAST_BIT_8);
  endproperty
  a_bits: assert property (p_bits) else $error("wrong bit count per word"); // [R18]
  property p_flag_irq;
    done && irq_en_reg[IRQ_RX_BIT] |=> flags_reg[IRQ_RX_BIT] ##1 IRQ_OUT;
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("flag or irq missing"); // [R11]
  property p_ninth;
    done && nine_reg && !full_reg |=> d9_reg == $past(din_s) && full_reg;
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit not captured"); // [R10]
  property p_err_clr;
    wr_rx_s && !w_data_reg[RX_CONTINUOUS_RECEIVE_ENABLE_BIT] && !done |=> !overrun_error_flag_reg;
  endproperty
  a_err_clr: assert property (p_err_clr) else $error("error not cleared"); // [R13]

  c_single: cover property (done && !continuous_receive_enable_reg);
  c_cont: cover property (done && continuous_receive_enable_reg ##[1:300] done);
  c_overrun: cover property ($rose(overrun_error_flag_reg));
endmodule

// ### tb/smsr_slave_model.sv
`timescale 1ns/1ps
// serial slave: shifts queued words out lsb first, moving on after each fall
module smsr_slave_model
(
  input wire logic clk_line_in, // shift clock from the master
  input wire logic nine_in, // nine-bit words
  input wire logic [7:0] lag_in, // ns from fall to next bit, slow or prompt
  output logic data_out // data line to the master
);
  logic [8:0] q[$];
  int idx = 0;
  initial data_out = 1'b0;
  // idle line toggles so a stale bit never looks like valid data
  task automatic drive();
    if (q.size() > 0)
      data_out = q[0][idx];
    else
      data_out = ~data_out;
  endtask
  task automatic push(input logic [8:0] wd);
    q.push_back(wd);
    drive();
  endtask
  task automatic flush();
    q.delete();
    idx = 0;
    drive();
  endtask
  // master samples at the fall, so the next bit follows it
  always @(negedge clk_line_in)
  begin
    #(lag_in);
    if (q.size() > 0)
    begin
      idx++;
      if (idx == (nine_in ? 9 : 8))
      begin
        void'(q.pop_front());
        idx = 0;
      end
    end
    drive();
  end
endmodule

// ### tb/smsr_top_tb_top.sv
`timescale 1ns/1ps
module smsr_top_tb_top;
  import smsr_pkg::*;
  localparam logic [11:0] A_FLG = {IDX_IRQ_FLAGS, 2'b00};
  localparam logic [11:0] A_RX = {IDX_RX_STAT, 2'b00};
  localparam logic [11:0] A_DAT = {IDX_RX_DATA, 2'b00};
  localparam logic [11:0] A_EN = {IDX_IRQ_EN, 2'b00};
  localparam logic [11:0] A_TX = {IDX_TX_STAT, 2'b00};
  localparam logic [11:0] A_DIV = {IDX_BAUD_DIV, 2'b00};
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, nine;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [3:0] wstrb;
  logic [7:0] lag, dv;
  logic [8:0] w;
  logic [1:0] r;
  logic sclk_d = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, sclk, sclk_oe, irq, sdata;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int bad_count, checks_done, seed, cyc, last_rise, last_period, rises, r0;
  logic [11:0] a_tab[6] = '{A_FLG, A_RX, A_DAT, A_EN, A_TX, A_DIV};
  logic [7:0] v_tab[6] = '{RST_IRQ_FLAGS, RST_RX_STAT, RST_RX_DATA, RST_IRQ_EN, RST_TX_STAT, RST_BAUD_DIV};

  smsr_top uut (.CLK_IN(clk), .SYS_RST_IN(rst), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .SERIAL_DATA_LINE_IN(sdata), .SERIAL_CLOCK_LINE_OUT(sclk), .SERIAL_CLOCK_LINE_OE_OUT(sclk_oe),
    .IRQ_OUT(irq));
  smsr_slave_model slave (.clk_line_in(sclk), .nine_in(nine), .lag_in(lag), .data_out(sdata));

  // 20 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // shift clock rises and rise-to-rise spacing in system cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    sclk_d <= sclk;
    if (sclk && !sclk_d)
    begin
      rises <= rises + 1;
      last_period <= cyc - last_rise;
      last_rise <= cyc;
    end
  end

  function automatic int exp_period(input logic [7:0] x);
    return 4 * (int'(x) + 1);
  endfunction

  function automatic logic [7:0] exp_stat(input logic nn, input logic [8:0] wd);
    return nn ? (8'hC0 | {7'h00, wd[8]}) : 8'h80;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one clock with a bound, so a stuck handshake ends the run
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 5000)
    begin
      bad_count++;
      $display("[FAIL] wait expected done seen timeout");
      report_and_stop();
    end
  endtask

  // address and data offered together, each released when taken
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] v);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done)
    begin
      tick(n);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        done = 1'b1;
    end
    r = bresp;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      tick(n);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  // poll the flag register until the receive flag shows
  task automatic wait_flag();
    int n;
    n = 0;
    do
    begin
      tick(n);
      axi_rd(A_FLG);
    end
    while (d[IRQ_RX_BIT] !== 1'b1);
  endtask

  initial
  begin
    seed = 3605;
    rst = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    nine = 1'b0;
    lag = 8'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      axi_rd(a_tab[i]);
      check("reset value", d & (i == 1 ? 32'hFE : 32'hFFFFFFFF), {24'h0, v_tab[i]});
    end
    axi_rd(12'h004);
    check("unmapped resp", r, RESP_SLVERR);
    check("unmapped data", d, 32'h0);
    // refused writes: misaligned address, and low strobe off
    axi_wr(12'h006, 8'h55);
    check("misaligned write", r, RESP_SLVERR);
    wstrb <= 4'h0;
    axi_wr(A_EN, 8'hFF);
    wstrb <= 4'hF;
    check("strobe off resp", r, RESP_OKAY);
    axi_rd(A_EN);
    check("strobe off", d, 32'h0);
    axi_wr(A_TX, 8'hFF);
    axi_rd(A_TX);
    check("tx unimplemented", d, 32'hF7);
    // divisor first, then mode bits, enables clear
    axi_wr(A_DIV, 8'h00);
    axi_wr(A_TX, 8'h90);
    axi_wr(A_RX, 8'h80);
    // drive enable is registered one edge after the write lands
    @(posedge clk);
    check("clock drive", sclk_oe, 1);
    for (int k = 0; k < 5; k++)
    begin
      dv = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed)) & 8'h07;
      w = 9'($random(seed));
      axi_wr(A_EN, (k == 2) ? 8'h00 : 8'h20);
      axi_wr(A_DIV, dv);
      nine <= k[0];
      lag <= 8'($random(seed)) & 8'h3F;
      slave.flush();
      slave.push(w);
      r0 = rises;
      axi_wr(A_RX, k[0] ? 8'hE0 : 8'hA0);
      wait_flag();
      check("word clocks", rises - r0, k[0] ? 9 : 8);
      check("clock period", last_period, exp_period(dv));
      check("irq", irq, k != 2);
      axi_rd(A_RX);
      check("rx status", d & (k[0] ? 32'hFF : 32'hFE), exp_stat(k[0], w));
      axi_rd(A_DAT);
      check("rx data", d, {24'h0, w[7:0]});
      axi_wr(A_FLG, 8'h20);
      r0 = rises;
      repeat (2) @(posedge clk);
      check("irq cleared", irq, 0);
      repeat (12 * (int'(dv) + 1)) @(posedge clk);
      check("clock stopped", rises - r0, 0);
    end
    // both enables: continuous words back to back
    axi_wr(A_DIV, 8'h01);
    nine <= 1'b0;
    slave.flush();
    for (int k = 0; k < 3; k++)
      slave.push(9'(k * 8'h5B + 8'h21));
    axi_wr(A_RX, 8'hB0);
    for (int k = 0; k < 3; k++)
    begin
      wait_flag();
      axi_rd(A_DAT);
      check("stream data", d, {24'h0, 8'(k * 8'h5B + 8'h21)});
      axi_wr(A_FLG, 8'h20);
    end
    // leave words unread so the next one overruns
    repeat (160) @(posedge clk);
    axi_rd(A_RX);
    check("overrun", d & 32'hFE, 32'hB2);
    axi_wr(A_RX, 8'h80);
    axi_rd(A_RX);
    check("error cleared", d & 32'hFE, 32'h80);
    r0 = rises;
    repeat (40) @(posedge clk);
    check("stream stopped", rises - r0, 0);
    report_and_stop();
  end
endmodule
